// ### common/dub_pkg.sv
// Shared constants for the dual-channel host bus port
`default_nettype none
package dub_pkg;
  // ***************************************************************
  // Bus widths
  // ***************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int SEL_W = 4;
  localparam int NUM_REGS = 16;

  // ***************************************************************
  // Register indices and fields seen by the port
  // ***************************************************************
  localparam logic [2:0] IDX_ISR = 3'h2;
  localparam logic [2:0] IDX_MCR = 3'h4;
  localparam logic [2:0] IDX_PWR = 3'h7;
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int PWR_OSC_BIT = 0;
  localparam int PWR_PUMP_BIT = 1;

  // ***************************************************************
  // Synchroniser vector layout
  // ***************************************************************
  localparam int SYNC_W = 19;
  localparam int SB_DATA = 0;
  localparam int SB_ADDR = 8;
  localparam int SB_WR = 11;
  localparam int SB_RD = 12;
  localparam int SB_CSB = 13;
  localparam int SB_CSA = 14;
  localparam int SB_ISO = 15;
  localparam int SB_STRAP = 16;
  localparam int SB_OSC = 17;
  localparam int SB_PUMP = 18;
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h1f800;

  // ***************************************************************
  // Power modes
  // ***************************************************************
  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'h1,
    PWR_OSC_OFF = 4'h2,
    PWR_PUMP_OFF = 4'h4,
    PWR_FULL = 4'h8
  } dub_pwr_e;
endpackage
`default_nettype wire

// ### hw/dub_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module dub_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ***************************************************************
  // One pair of flops per bit; first stage feeds only the second
  // ***************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_q[i] <= RST_VAL[i];
          sync_q[i] <= RST_VAL[i];
        end else begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### hw/dub_reg_mem.sv
// Register shadow store for both channels, registered read data
`default_nettype none
module dub_reg_mem
  import dub_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_sel,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [SEL_W-1:0] rd_sel,
  output logic [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem_q [NUM_REGS];
  logic [DATA_W-1:0] rd_data_q;

  // Storage array, written at the end of a host write
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[wr_sel] <= wr_data;
    end
  end

  // Read data leave through a register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem_q[rd_sel];
    end
  end

  assign rd_data = rd_data_q;
endmodule
`default_nettype wire

// ### hw/dub_bus_port.sv
// Host parallel bus port of the two-channel serial controller
`default_nettype none
// Functional notes
// - Three address bits pick one register of the chosen channel.
// - Eight-bit data bus; device drives only while a read is active.
// - Strobe style: read strobe low starts read, byte driven until strobe rises.
// - Strobe style: write strobe rising stores the bus byte into register.
// - Strap high selects strobe style; low selects direction style, read strobe ignored.
// - Direction style: write strobe pin is direction, high read, low write.
// - Strobe style: two active-low selects enable channel A or channel B.
// - Direction style: first select pin is the single select for both.
// - Direction style: second select pin is channel bit, zero A, one B.
// - Strobe style: channel A interrupt active high, enabled by its control bit 3.
// - Strobe style: channel B interrupt likewise enabled by its own bit 3.
// - Direction style: one active-low open-drain interrupt for both channels.
// - Direction style: channel B interrupt pin unused and left undriven.
// - After power-up the device is in active mode.
// - Four power modes: active, oscillator off, pump off, both off.
// - Asleep with isolation requested, all bus inputs are ignored.
// - Each power mode enterable by hardware pin or software register.
// - Returning to active mode from any low-power mode raises a wake-up interrupt.
module dub_bus_port
  import dub_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus_style_strap,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic channel_a_irq,
  output logic channel_a_irq_oe,
  output logic channel_b_irq,
  output logic channel_b_irq_oe,
  input wire logic bus_isolation_request,
  input wire logic osc_sleep_req,
  input wire logic pump_sleep_req,
  input wire logic chan_a_int_req,
  input wire logic chan_b_int_req,
  output logic reg_wr_pulse,
  output logic [SEL_W-1:0] reg_wr_sel,
  output logic [DATA_W-1:0] reg_wr_data,
  output logic reg_rd_pulse,
  output logic [SEL_W-1:0] reg_rd_sel,
  output logic osc_stop,
  output logic pump_stop,
  output logic [3:0] power_mode
);
  // ***************************************************************
  // Pin synchronisation
  // ***************************************************************
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;

  assign pin_raw = {pump_sleep_req, osc_sleep_req, bus_style_strap,
                    bus_isolation_request, channel_a_select_n,
                    channel_b_select_n, read_strobe_n, write_strobe_n,
                    addr_in, data_in};

  dub_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in(pin_raw),
    .sync_out(pin_s)
  );

  // Named views of the synchronised pins
  wire style_strobe = pin_s[SB_STRAP];
  wire iso_s = pin_s[SB_ISO];
  wire csa_s = pin_s[SB_CSA];
  wire csb_s = pin_s[SB_CSB];
  wire rd_s = pin_s[SB_RD];
  wire wr_s = pin_s[SB_WR];
  wire osc_hw_s = pin_s[SB_OSC];
  wire pump_hw_s = pin_s[SB_PUMP];
  wire [ADDR_W-1:0] addr_s = pin_s[SB_ADDR +: ADDR_W];
  wire [DATA_W-1:0] data_s = pin_s[SB_DATA +: DATA_W];

  // ***************************************************************
  // State
  // ***************************************************************
  dub_pwr_e pwr_q, pwr_d;
  logic rd_act_q;
  logic wr_act_q;
  logic [ADDR_W-1:0] lat_addr_q;
  logic lat_ch_q;
  logic [DATA_W-1:0] lat_data_q;
  logic [1:0] mcr_ie_q;
  logic [1:0] pwr_sw_q;
  logic wake_q;
  logic [DATA_W-1:0] data_out_q;
  logic data_oe_q;
  logic irq_a_q, irq_a_oe_q, irq_b_q, irq_b_oe_q;
  logic reg_wr_pulse_q, reg_rd_pulse_q;
  logic [SEL_W-1:0] reg_wr_sel_q, reg_rd_sel_q;
  logic [DATA_W-1:0] reg_wr_data_q;
  logic osc_stop_q, pump_stop_q;
  logic [DATA_W-1:0] mem_rdata;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  // Bus is gated off while asleep with isolation requested
  wire asleep = (pwr_q != PWR_ACTIVE);
  wire bus_ok = !(asleep && iso_s);
  // Strobe style: either select low; direction style: first select only
  wire any_sel = style_strobe ? (!csa_s || !csb_s) : !csa_s;
  // Channel bit: select A wins in strobe style, second pin otherwise
  wire ch_now = style_strobe ? csa_s : csb_s;
  // Read active: strobe low, or direction high under select
  wire rd_act = bus_ok && any_sel &&
                (style_strobe ? !rd_s : wr_s);
  // Write active: strobe low, or direction low under select
  wire wr_act = bus_ok && any_sel && !wr_s;
  wire rd_start = rd_act && !rd_act_q;
  // Write ends on strobe rising, or on select rising in direction style
  wire wr_end = bus_ok && wr_act_q &&
                (style_strobe ? wr_s : csa_s);
  wire [SEL_W-1:0] cur_sel = {ch_now, addr_s};
  wire [SEL_W-1:0] lat_sel = {lat_ch_q, lat_addr_q};
  wire wr_mcr = wr_end && (lat_addr_q == IDX_MCR);
  wire wr_pwr = wr_end && (lat_addr_q == IDX_PWR) && !lat_ch_q;
  wire rd_isr = rd_start && (addr_s == IDX_ISR);

  dub_reg_mem u_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .wr_en(wr_end),
    .wr_sel(lat_sel),
    .wr_data(lat_data_q),
    .rd_sel(cur_sel),
    .rd_data(mem_rdata)
  );

  // Transaction tracking and write capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      lat_addr_q <= '0;
      lat_ch_q <= 1'b0;
      lat_data_q <= '0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        lat_addr_q <= addr_s;
        lat_ch_q <= ch_now;
        lat_data_q <= data_s;
      end
    end
  end

  // Control bits shadowed from register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mcr_ie_q <= 2'h0;
      pwr_sw_q <= 2'h0;
    end else begin
      if (wr_mcr) begin
        mcr_ie_q[lat_ch_q] <= lat_data_q[MCR_IRQ_EN_BIT];
      end
      if (wr_pwr) begin
        pwr_sw_q <= {lat_data_q[PWR_PUMP_BIT], lat_data_q[PWR_OSC_BIT]};
      end
    end
  end

  // ***************************************************************
  // Power modes
  // ***************************************************************
  wire osc_off = osc_hw_s || pwr_sw_q[0];
  wire pump_off = pump_hw_s || pwr_sw_q[1];

  // Mode follows the merged hardware and software requests
  always_comb begin
    case ({pump_off, osc_off})
      2'h1: pwr_d = PWR_OSC_OFF;
      2'h2: pwr_d = PWR_PUMP_OFF;
      2'h3: pwr_d = PWR_FULL;
      default: pwr_d = PWR_ACTIVE;
    endcase
  end

  wire wake_evt = asleep && (pwr_d == PWR_ACTIVE);

  // Mode register and wake flag; a new wake event beats the clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q <= PWR_ACTIVE;
      wake_q <= 1'b0;
      osc_stop_q <= 1'b0;
      pump_stop_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      osc_stop_q <= osc_off;
      pump_stop_q <= pump_off;
      if (wake_evt) begin
        wake_q <= 1'b1;
      end else if (rd_isr) begin
        wake_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Data bus and core strobes
  // ***************************************************************
  // Drive data only while a read is in progress
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_q <= '0;
      data_oe_q <= 1'b0;
    end else begin
      data_out_q <= mem_rdata;
      data_oe_q <= rd_act && rd_act_q;
    end
  end

  // Pulses and addresses toward the channel cores
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_wr_pulse_q <= 1'b0;
      reg_wr_sel_q <= '0;
      reg_wr_data_q <= '0;
      reg_rd_pulse_q <= 1'b0;
      reg_rd_sel_q <= '0;
    end else begin
      reg_wr_pulse_q <= wr_end;
      reg_rd_pulse_q <= rd_start;
      if (wr_end) begin
        reg_wr_sel_q <= lat_sel;
        reg_wr_data_q <= lat_data_q;
      end
      if (rd_start) begin
        reg_rd_sel_q <= cur_sel;
      end
    end
  end

  // ***************************************************************
  // Interrupt pins
  // ***************************************************************
  wire int_any = chan_a_int_req || chan_b_int_req || wake_q;

  // Per-channel high pins, or one shared open-drain low pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_a_q <= 1'b0;
      irq_a_oe_q <= 1'b0;
      irq_b_q <= 1'b0;
      irq_b_oe_q <= 1'b0;
    end else if (style_strobe) begin
      irq_a_q <= chan_a_int_req || wake_q;
      irq_a_oe_q <= mcr_ie_q[0];
      irq_b_q <= chan_b_int_req;
      irq_b_oe_q <= mcr_ie_q[1];
    end else begin
      irq_a_q <= 1'b0;
      irq_a_oe_q <= int_any;
      irq_b_q <= 1'b0;
      irq_b_oe_q <= 1'b0;
    end
  end

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;
  assign channel_a_irq = irq_a_q;
  assign channel_a_irq_oe = irq_a_oe_q;
  assign channel_b_irq = irq_b_q;
  assign channel_b_irq_oe = irq_b_oe_q;
  assign reg_wr_pulse = reg_wr_pulse_q;
  assign reg_wr_sel = reg_wr_sel_q;
  assign reg_wr_data = reg_wr_data_q;
  assign reg_rd_pulse = reg_rd_pulse_q;
  assign reg_rd_sel = reg_rd_sel_q;
  assign osc_stop = osc_stop_q;
  assign pump_stop = pump_stop_q;
  assign power_mode = pwr_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_addr_decode: assert property (
    rd_start |=> reg_rd_pulse_q && reg_rd_sel_q == $past(cur_sel))
    else $error("read address not decoded");

  chk_read_drive: assert property (
    (rd_start ##1 rd_act) |=> data_oe_q && data_out_q == $past(mem_rdata))
    else $error("read byte not driven");

  chk_no_drive_write: assert property (
    (wr_act && !rd_act) |=> !data_oe_q)
    else $error("data driven during write");

  chk_write_store: assert property (
    wr_end |=> reg_wr_pulse_q && reg_wr_data_q == $past(lat_data_q))
    else $error("write byte not stored");

  chk_rd_ignored: assert property (
    (!style_strobe && (csa_s || !wr_s)) |-> !rd_act)
    else $error("read strobe used in direction style");

  chk_dir_read: assert property (
    (!style_strobe && !csa_s && wr_s && bus_ok) ##1 rd_act |=> data_oe_q)
    else $error("direction high did not read");

  chk_chan_a_sel: assert property (
    (style_strobe && !csa_s && wr_act) |=> lat_ch_q == 1'b0)
    else $error("select A did not pick channel A");

  chk_chan_bit: assert property (
    (!style_strobe && wr_act) |=> lat_ch_q == $past(csb_s))
    else $error("channel bit not honoured");

  chk_irq_a_gate: assert property (
    style_strobe |=> channel_a_irq_oe == $past(mcr_ie_q[0]))
    else $error("channel A enable wrong");

  chk_irq_b_gate: assert property (
    style_strobe |=> channel_b_irq_oe == $past(mcr_ie_q[1]))
    else $error("channel B enable wrong");

  chk_irq_shared: assert property (
    !style_strobe |=> !channel_a_irq && !channel_b_irq_oe &&
      channel_a_irq_oe == $past(int_any))
    else $error("shared interrupt wrong");

  chk_isolate_bus: assert property (
    (asleep && iso_s) |=> !reg_wr_pulse_q && !reg_rd_pulse_q)
    else $error("bus not isolated");

  chk_wake_irq: assert property (
    wake_evt |=> wake_q ##1 (!style_strobe || channel_a_irq))
    else $error("no wake interrupt");

  cov_strobe_read: cover property (style_strobe && rd_start ##[1:8] !rd_act);
  cov_dir_write: cover property (!style_strobe && wr_end);
  cov_full_sleep: cover property (pwr_q == PWR_FULL ##[1:50] wake_evt);
  cov_isolated: cover property (asleep && iso_s && !csa_s);
endmodule
`default_nettype wire

// ### testbench/dub_host_model.sv
// Host processor model driving the parallel bus pins
`default_nettype none
module dub_host_model
  import dub_pkg::*;
(
  input wire logic mclk,
  input wire logic noise_rd,
  input wire logic [DATA_W-1:0] data_out,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic channel_a_select_n,
  output logic channel_b_select_n,
  output logic [ADDR_W-1:0] addr_in,
  output logic [DATA_W-1:0] host_bus
);
  // Idle pins at time zero
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    addr_in = '0;
    host_bus = '0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One byte transfer; active phase held 6 edges, release phase 5 edges, idle 4 edges
  task automatic xfer(input logic strobe, input logic wr, input logic chan,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    @(posedge mclk);
    addr_in <= a;
    if (wr) begin
      host_bus <= d;
    end
    if (strobe) begin
      read_strobe_n <= wr;
      write_strobe_n <= ~wr;
      channel_a_select_n <= chan;
      channel_b_select_n <= ~chan;
    end else begin
      write_strobe_n <= ~wr;
      channel_a_select_n <= 1'b0;
      channel_b_select_n <= chan;
      read_strobe_n <= ~noise_rd;
    end
    hold(6);
    q = data_out;
    if (strobe) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      channel_a_select_n <= 1'b1;
    end
    hold(5);
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    channel_a_select_n <= 1'b1;
    channel_b_select_n <= 1'b1;
    host_bus <= ~host_bus;
    hold(4);
  endtask
endmodule
`default_nettype wire

// ### testbench/dub_bus_port_tb.sv
// Self-checking bench for the host bus port
`default_nettype none
module dub_bus_port_tb
  import dub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic strobe;
    logic chan;
    logic [2:0] addr;
    logic [7:0] data;
  } dub_row_s;
  logic mclk, arst_n, strap, iso, osc_req, pump_req, int_a, int_b, noise_rd;
  logic rd_n, wr_n, csa_n, csb_n, data_oe, irq_a, irq_a_oe, irq_b, irq_b_oe;
  logic wr_p, rd_p, osc_stop, pump_stop;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, host_bus, wr_dat, rq;
  logic [3:0] wr_sel, rd_sel, m_wr_sel, m_rd_sel, power_mode;
  int errors, num_checks, wr_cnt, rd_cnt, n0, r0;
  dub_row_s rows [6] = '{'{1'b1, 1'b0, 3'h0, 8'ha5}, '{1'b1, 1'b1, 3'h1, 8'h5a},
    '{1'b0, 1'b0, 3'h3, 8'h3c}, '{1'b0, 1'b1, 3'h6, 8'hc3},
    '{1'b1, 1'b0, 3'h5, 8'h00}, '{1'b0, 1'b1, 3'h0, 8'hff}};
  logic [11:0] sw_rows [4] = '{12'h012, 12'h024, 12'h038, 12'h001};

  // Bus wire level: device drive wins, else host pattern
  assign data_in = data_oe ? data_out : host_bus;

  dub_bus_port dub_bus_port_i (.mclk(mclk), .arst_n(arst_n), .bus_style_strap(strap),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .channel_a_select_n(csa_n),
    .channel_b_select_n(csb_n), .addr_in(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .channel_a_irq(irq_a), .channel_a_irq_oe(irq_a_oe),
    .channel_b_irq(irq_b), .channel_b_irq_oe(irq_b_oe), .bus_isolation_request(iso),
    .osc_sleep_req(osc_req), .pump_sleep_req(pump_req), .chan_a_int_req(int_a),
    .chan_b_int_req(int_b), .reg_wr_pulse(wr_p), .reg_wr_sel(wr_sel),
    .reg_wr_data(wr_dat), .reg_rd_pulse(rd_p), .reg_rd_sel(rd_sel), .osc_stop(osc_stop),
    .pump_stop(pump_stop), .power_mode(power_mode));

  dub_host_model dub_host_model_i (.mclk(mclk), .noise_rd(noise_rd), .data_out(data_in),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .channel_a_select_n(csa_n),
    .channel_b_select_n(csb_n), .addr_in(addr), .host_bus(host_bus));

  // ***************************************************************
  // Clock, monitor and helpers
  // ***************************************************************
  always #50 mclk = ~mclk;

  // Count register pulses and keep their qualifiers
  always @(posedge mclk) begin
    if (wr_p === 1'b1) begin
      wr_cnt++;
      m_wr_sel = wr_sel;
    end
    if (rd_p === 1'b1) begin
      rd_cnt++;
      m_rd_sel = rd_sel;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic op(input logic s, input logic w, input logic c, input logic [2:0] a,
                    input logic [7:0] d);
    dub_host_model_i.xfer(s, w, c, a, d, rq);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Watchdog against a hung run
  initial begin
    #2000000;
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    results();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    {strap, iso, osc_req, pump_req, int_a, int_b, noise_rd} = 7'h40;
    wr_cnt = 0;
    rd_cnt = 0;
    wait_clk(2);
    check({4'h0, power_mode}, 8'h01, "reset mode");
    check({7'h0, data_oe}, 8'h00, "reset drive");
    arst_n <= 1'b1;
    wait_clk(3);
    $display("test reset done");
    foreach (rows[i]) begin
      strap <= rows[i].strobe;
      wait_clk(4);
      n0 = wr_cnt;
      r0 = rd_cnt;
      op(rows[i].strobe, 1'b1, rows[i].chan, rows[i].addr, rows[i].data);
      check(8'(wr_cnt - n0), 8'h01, "write count");
      check({4'h0, m_wr_sel}, {4'h0, rows[i].chan, rows[i].addr}, "write sel");
      check(wr_dat, rows[i].data, "write data");
      op(rows[i].strobe, 1'b0, rows[i].chan, rows[i].addr, 8'h00);
      check(8'(rd_cnt - r0), 8'h01, "read count");
      check({4'h0, m_rd_sel}, {4'h0, rows[i].chan, rows[i].addr}, "read sel");
      check(rq, rows[i].data, "read data");
      check({7'h0, data_oe}, 8'h00, "drive released");
    end
    $display("test rows done");
    // Read strobe held low in direction style must not start a read
    noise_rd <= 1'b1;
    r0 = rd_cnt;
    op(1'b0, 1'b1, 1'b0, 3'h1, 8'h77);
    check(8'(rd_cnt - r0), 8'h00, "ignored strobe");
    check(wr_dat, 8'h77, "noisy write");
    noise_rd <= 1'b0;
    $display("test ignore done");
    // Strobe-style interrupt enables per channel
    strap <= 1'b1;
    wait_clk(4);
    op(1'b1, 1'b1, 1'b0, IDX_MCR, 8'h08);
    op(1'b1, 1'b1, 1'b1, IDX_MCR, 8'h00);
    int_a <= 1'b1;
    int_b <= 1'b1;
    wait_clk(3);
    check({6'h0, irq_a_oe, irq_a}, 8'h03, "irq a on");
    check({7'h0, irq_b_oe}, 8'h00, "irq b off");
    op(1'b1, 1'b1, 1'b1, IDX_MCR, 8'h08);
    check({6'h0, irq_b_oe, irq_b}, 8'h03, "irq b on");
    int_a <= 1'b0;
    int_b <= 1'b0;
    wait_clk(3);
    check({6'h0, irq_a, irq_b}, 8'h00, "irq idle");
    $display("test irq strobe done");
    // Hardware sleep with isolation, then wake
    iso <= 1'b1;
    osc_req <= 1'b1;
    wait_clk(4);
    check({2'h0, osc_stop, pump_stop, power_mode}, 8'h22, "osc off");
    n0 = wr_cnt;
    op(1'b1, 1'b1, 1'b0, 3'h1, 8'h99);
    check(8'(wr_cnt - n0), 8'h00, "isolated write");
    pump_req <= 1'b1;
    wait_clk(4);
    check({4'h0, power_mode}, 8'h08, "full sleep");
    osc_req <= 1'b0;
    wait_clk(4);
    check({4'h0, power_mode}, 8'h04, "pump off");
    pump_req <= 1'b0;
    iso <= 1'b0;
    wait_clk(5);
    check({4'h0, power_mode}, 8'h01, "awake");
    check({7'h0, irq_a}, 8'h01, "wake irq");
    op(1'b1, 1'b0, 1'b0, IDX_ISR, 8'h00);
    wait_clk(2);
    check({7'h0, irq_a}, 8'h00, "wake cleared");
    $display("test sleep hw done");
    // Software power bits for every mode
    foreach (sw_rows[i]) begin
      op(1'b1, 1'b1, 1'b0, IDX_PWR, sw_rows[i][11:4]);
      wait_clk(3);
      check({4'h0, power_mode}, {4'h0, sw_rows[i][3:0]}, "soft mode");
    end
    check({7'h0, irq_a}, 8'h01, "soft wake");
    op(1'b1, 1'b0, 1'b1, IDX_ISR, 8'h00);
    $display("test sleep sw done");
    // Direction style shared open-drain interrupt
    op(1'b1, 1'b1, 1'b0, IDX_MCR, 8'h00);
    strap <= 1'b0;
    int_b <= 1'b1;
    wait_clk(4);
    check({5'h0, irq_a_oe, irq_a, irq_b_oe}, 8'h04, "shared irq");
    int_b <= 1'b0;
    wait_clk(3);
    check({6'h0, irq_a_oe, irq_b_oe}, 8'h00, "shared idle");
    $display("test irq shared done");
    results();
  end
endmodule
`default_nettype wire
